// [design/pmcc_params.svh]
// Constants of the power-mode and clock configuration block.
// Assumes one 250 MHz clock and word-aligned single AHB-Lite transfers.
// Contract
// - Option word at 7FCh, erased value 3FFFh
// - Option bit 13 low enables read protection
// - Protect first half while reuse bit is one
// - Reuse bit zero protects all but top area
// - 2K words; reuse moves vectors to 400h
// - Bits 11-10 pick low-voltage reset and detect
// - Bit 7 enables external reset pin
// - Bits 6-5 pick watchdog reset mode
// - Sleep instruction enters IDLE or STOP
// - Writing power_down_entry enters power-down
// - Power-down stops system clock and peripherals
// - Reset, enabled interrupts or pin low wake
// - Four oscillators, any drives system clock
// - IDLE keeps only slow clock for wake timer
// - Source bit enters FAST; type bit picks oscillator
// - FAST clocks general timer; PWM select bit
// - Any reset starts SLOW on slow RC
// - Slow stop clear: sleep enters IDLE
// - Slow stop set: sleep enters STOP, no clocks
// - Source bit zero slow, one fast
// - Fast stop bit one disables fast oscillator
// - Prescale codes 00-11 divide 16,4,2,1
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH
`define PMCC_OPT_ADDR      11'h7FC
`define PMCC_OPT_ERASED    14'h3FFF
`define PMCC_OPT_PROT      13
`define PMCC_OPT_REUSE     12
`define PMCC_OPT_LV_HI     11
`define PMCC_OPT_LV_LO     10
`define PMCC_OPT_XRST      7
`define PMCC_OPT_WD_HI     6
`define PMCC_OPT_WD_LO     5
`define PMCC_HALF_ADDR     11'h400
`define PMCC_TOP_ADDR      11'h7FC
`define PMCC_RST_VEC       11'h000
`define PMCC_LV_OFF        2'h2
`define PMCC_LV_LOW        2'h3
`define PMCC_WD_RUN        2'h2
`define PMCC_WD_ALL        2'h3
`define PMCC_IDX_PDE       8'h03
`define PMCC_IDX_CLK       8'h04
`define PMCC_IDX_STAT      8'h05
`define PMCC_IDX_OPT       8'h06
`define PMCC_CK_SLOW_TYPE  7
`define PMCC_CK_FAST_TYPE  6
`define PMCC_CK_SLOW_STOP  4
`define PMCC_CK_FAST_STOP  3
`define PMCC_CK_SRC        2
`define PMCC_CK_PWM        8
`define PMCC_CLK_RESET     9'h003
`define PMCC_CLK_MASK      9'h1DF
`endif

// [design/pmcc_pkg.sv]
// Types of the power-mode and clock configuration block.
// Assumes the constants header is included by the design file.
package pmcc_pkg;
  // Operating mode; LOAD is the option fetch right after reset
  typedef enum logic [2:0] {
    PMCC_LOAD, PMCC_FAST, PMCC_SLOW, PMCC_IDLE, PMCC_STOP
  } pmcc_mode_t;
  // Oscillator enables
  typedef struct packed {
    logic fast_crystal;
    logic fast_internal_rc;
    logic slow_crystal;
    logic slow_internal_rc;
  } pmcc_osc_t;
  // Decoded option word fields
  typedef struct packed {
    logic       read_protect;
    logic       reuse_mode;
    logic       ext_pin_reset_en;
    logic       watchdog_reset_en;
    logic       low_voltage_reset_en;
    logic       low_voltage_detect_en;
    logic [1:0] low_voltage_level;
  } pmcc_opt_t;
endpackage

// [design/pmcc_top.sv]
// Power-mode and clock configuration: option word, mode control, AHB-Lite registers.
// Assumes an AHB-Lite master on hclk and an option word steady on opt_word at reset.
//
// Added by the designer: the AHB-Lite register port.
`include "pmcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmcc_top import pmcc_pkg::*; (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Option word store
  input  wire logic [13:0] opt_word,
  output logic [10:0]      opt_addr,
  // Core events and wake sources
  input  wire logic        sleep_req,
  input  wire logic        ext_irq_wake,
  input  wire logic        wake_timer_irq,
  input  wire logic [5:0]  port_a_wake_n,
  input  wire logic [5:0]  port_b_wake_n,
  // Program memory read check
  input  wire logic [10:0] prog_rd_addr,
  output logic             prog_rd_blocked,
  output logic [10:0]      reset_vector,
  output logic [10:0]      irq_vector,
  // Mode and clock control
  output pmcc_mode_t       mode,
  output pmcc_osc_t        osc_en,
  output pmcc_opt_t        opt,
  output logic             sysclk_fast,
  output logic [4:0]       sysclk_div,
  output logic             sysclk_tick,
  output logic             cpu_run,
  output logic             general_timer_run,
  output logic             pwm_clk_fast_irc,
  output logic             wake_timer_run,
  output logic             wake_timer_src_crystal
);

  // Division factor of a prescale code
  function automatic logic [4:0] psc_div(input logic [1:0] code);
    unique case (code)
      2'h0: psc_div = 5'h10;
      2'h1: psc_div = 5'h04;
      2'h2: psc_div = 5'h02;
      2'h3: psc_div = 5'h01;
    endcase
  endfunction

  // Latched option word, clock control and bus phase state
  logic [13:0] opt_q;
  logic [8:0]  clk_ctl;
  logic        ph_wr;
  logic        ph_rd;
  logic [7:0]  ph_idx;
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic [11:0] sync3;
  logic [3:0]  tick_cnt;
  pmcc_mode_t  next_mode;
  logic        run;
  logic        pde_wr;
  logic        pd_req;
  logic        pin_low;
  logic        wake;
  logic [1:0]  wd_mode;
  logic [1:0]  lv_mode;

  // Run covers both clocked modes; option fields come from the latched word only
  assign run     = (mode == PMCC_FAST) || (mode == PMCC_SLOW);
  assign wd_mode = opt_q[`PMCC_OPT_WD_HI:`PMCC_OPT_WD_LO];
  assign lv_mode = opt_q[`PMCC_OPT_LV_HI:`PMCC_OPT_LV_LO];

  // Bus address phase; zero wait states, every answer OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ph_idx <= 8'h00;
    end else if (hready) begin
      ph_wr  <= hsel && htrans[1] && hwrite;
      ph_rd  <= hsel && htrans[1] && !hwrite;
      ph_idx <= haddr[9:2];
    end
  end

  // Handshake outputs stay fixed; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is staged in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[9:2])
        `PMCC_IDX_CLK:  hrdata <= {23'h000000, clk_ctl};
        `PMCC_IDX_STAT: hrdata <= {29'h00000000, mode};
        `PMCC_IDX_OPT:  hrdata <= {18'h00000, opt_q};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Clock control register; type bits are not guarded, software sequences them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_ctl <= `PMCC_CLK_RESET;
    end else if (ph_wr && ph_idx == `PMCC_IDX_CLK) begin
      clk_ctl <= hwdata[8:0] & `PMCC_CLK_MASK;
    end
  end

  // Option word is fetched once, in the cycle after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q    <= `PMCC_OPT_ERASED;
      opt_addr <= `PMCC_OPT_ADDR;
    end else if (mode == PMCC_LOAD) begin
      opt_q    <= opt_word;
    end
  end

  // Wake pins: three stages, a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 12'hFFF;
      sync2 <= 12'hFFF;
      sync3 <= 12'hFFF;
    end else begin
      sync1 <= {port_b_wake_n, port_a_wake_n};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Wake and power-down requests; a pin counts only once two sync stages agree
  assign pin_low = |(~sync2 & ~sync3);
  assign wake    = ext_irq_wake || wake_timer_irq || pin_low;
  assign pde_wr  = ph_wr && (ph_idx == `PMCC_IDX_PDE);
  assign pd_req  = sleep_req || pde_wr;

  // Mode sequencing; stop bit decides between IDLE and STOP
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PMCC_LOAD: next_mode = PMCC_SLOW;
      PMCC_FAST, PMCC_SLOW: begin
        if (pd_req) begin
          next_mode = clk_ctl[`PMCC_CK_SLOW_STOP] ? PMCC_STOP : PMCC_IDLE;
        end else begin
          next_mode = clk_ctl[`PMCC_CK_SRC] ? PMCC_FAST : PMCC_SLOW;
        end
      end
      PMCC_IDLE, PMCC_STOP: begin
        if (wake) begin
          next_mode = clk_ctl[`PMCC_CK_SRC] ? PMCC_FAST : PMCC_SLOW;
        end
      end
    endcase
  end

  // Mode register; LOAD lasts one edge so the option word is in place before the core runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= PMCC_LOAD;
    end else begin
      mode <= next_mode;
    end
  end

  // Oscillator enables follow the mode entered on this edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_en <= '{1'b0, 1'b0, 1'b0, 1'b1};
    end else begin
      osc_en.fast_crystal     <= (next_mode == PMCC_FAST || next_mode == PMCC_SLOW)
                                 && !clk_ctl[`PMCC_CK_FAST_STOP] && clk_ctl[`PMCC_CK_FAST_TYPE];
      osc_en.fast_internal_rc <= (next_mode == PMCC_FAST || next_mode == PMCC_SLOW)
                                 && !clk_ctl[`PMCC_CK_FAST_STOP] && !clk_ctl[`PMCC_CK_FAST_TYPE];
      osc_en.slow_crystal     <= (next_mode != PMCC_STOP) && clk_ctl[`PMCC_CK_SLOW_TYPE];
      osc_en.slow_internal_rc <= (next_mode != PMCC_STOP) && !clk_ctl[`PMCC_CK_SLOW_TYPE];
    end
  end

  // Clock gating of core and peripherals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysclk_fast            <= 1'b0;
      cpu_run                <= 1'b0;
      general_timer_run      <= 1'b0;
      pwm_clk_fast_irc       <= 1'b0;
      wake_timer_run         <= 1'b0;
      wake_timer_src_crystal <= 1'b0;
    end else begin
      sysclk_fast            <= next_mode == PMCC_FAST;
      cpu_run                <= next_mode == PMCC_FAST || next_mode == PMCC_SLOW;
      general_timer_run      <= next_mode == PMCC_FAST || next_mode == PMCC_SLOW;
      pwm_clk_fast_irc       <= clk_ctl[`PMCC_CK_PWM];
      wake_timer_run         <= next_mode != PMCC_STOP && next_mode != PMCC_LOAD;
      wake_timer_src_crystal <= clk_ctl[`PMCC_CK_SLOW_TYPE];
    end
  end

  // Prescaler: one tick per divided system clock, held off in power-down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysclk_div  <= 5'h01;
      sysclk_tick <= 1'b0;
      tick_cnt    <= 4'h0;
    end else begin
      sysclk_div <= psc_div(clk_ctl[1:0]);
      if (!run) begin
        sysclk_tick <= 1'b0;
        tick_cnt    <= 4'h0;
      end else if ({1'b0, tick_cnt} >= psc_div(clk_ctl[1:0]) - 5'h01) begin
        sysclk_tick <= 1'b1;
        tick_cnt    <= 4'h0;
      end else begin
        sysclk_tick <= 1'b0;
        tick_cnt    <= tick_cnt + 4'h1;
      end
    end
  end

  // Option field decode; watchdog tracks the mode being entered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt <= '0;
    end else begin
      opt.read_protect          <= !opt_q[`PMCC_OPT_PROT];
      opt.reuse_mode            <= !opt_q[`PMCC_OPT_REUSE];
      opt.ext_pin_reset_en      <= opt_q[`PMCC_OPT_XRST];
      opt.watchdog_reset_en     <= wd_mode == `PMCC_WD_ALL ||
                                   (wd_mode == `PMCC_WD_RUN &&
                                    (next_mode == PMCC_FAST || next_mode == PMCC_SLOW));
      opt.low_voltage_reset_en  <= lv_mode != `PMCC_LV_OFF;
      opt.low_voltage_detect_en <= lv_mode != `PMCC_LV_OFF && lv_mode != `PMCC_LV_LOW;
      opt.low_voltage_level     <= lv_mode;
    end
  end

  // Read protection and vector placement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_rd_blocked <= 1'b1;
      reset_vector    <= `PMCC_RST_VEC;
      irq_vector      <= `PMCC_RST_VEC + 11'h001;
    end else begin
      if (opt_q[`PMCC_OPT_PROT]) begin
        prog_rd_blocked <= 1'b0;
      end else if (opt_q[`PMCC_OPT_REUSE]) begin
        prog_rd_blocked <= prog_rd_addr < `PMCC_HALF_ADDR;
      end else begin
        prog_rd_blocked <= prog_rd_addr < `PMCC_TOP_ADDR;
      end
      reset_vector <= opt_q[`PMCC_OPT_REUSE] ? `PMCC_RST_VEC : `PMCC_HALF_ADDR;
      irq_vector   <= (opt_q[`PMCC_OPT_REUSE] ? `PMCC_RST_VEC : `PMCC_HALF_ADDR) + 11'h001;
    end
  end

  // All checks run on hclk and are off while reset is held
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence sleep_in_run_s;
    run && sleep_req;
  endsequence

  sequence stopped_s;
    mode == PMCC_STOP ##0 osc_en == 4'h0;
  endsequence

  sequence powered_down_s;
    mode inside {PMCC_IDLE, PMCC_STOP};
  endsequence

  load_to_slow_a: assert property (mode == PMCC_LOAD && hresetn |=> mode == PMCC_SLOW)
    else $error("reset did not lead to SLOW");
  sleep_idle_a: assert property (sleep_in_run_s ##0 !clk_ctl[`PMCC_CK_SLOW_STOP] |=> mode == PMCC_IDLE)
    else $error("sleep with slow clock kept did not enter IDLE");
  sleep_stop_a: assert property (sleep_in_run_s ##0 clk_ctl[`PMCC_CK_SLOW_STOP] |=> stopped_s)
    else $error("sleep with slow stop did not halt all oscillators");
  pde_write_a: assert property (run && pde_wr |=> mode inside {PMCC_IDLE, PMCC_STOP})
    else $error("power_down_entry write ignored");
  pd_gating_a: assert property (mode inside {PMCC_IDLE, PMCC_STOP} |-> !cpu_run && !general_timer_run)
    else $error("clocks running in power-down");
  wake_exit_a: assert property (mode == PMCC_IDLE && ext_irq_wake |=> run ##1 cpu_run)
    else $error("interrupt did not end IDLE");
  fast_select_a: assert property (run && !pd_req && clk_ctl[`PMCC_CK_SRC] |=> mode == PMCC_FAST && sysclk_fast)
    else $error("source bit did not select FAST");
  prescale_a: assert property (1'b1 |=> sysclk_div == psc_div($past(clk_ctl[1:0])))
    else $error("prescale factor wrong");
  half_protect_a: assert property (mode != PMCC_LOAD && !opt_q[`PMCC_OPT_PROT] && opt_q[`PMCC_OPT_REUSE]
                                   |=> prog_rd_blocked == ($past(prog_rd_addr) < `PMCC_HALF_ADDR))
    else $error("first-half protection wrong");
  watchdog_a: assert property (mode == PMCC_IDLE && wd_mode == `PMCC_WD_RUN |-> !opt.watchdog_reset_en)
    else $error("watchdog reset active in power-down");
  opt_hold_a: assert property (mode != PMCC_LOAD |=> $stable(opt_q))
    else $error("option word changed after fetch");

  // Power-down and FAST clocking, wake pins and decoded option fields
  stop_clocks_a: assert property (mode == PMCC_STOP |-> osc_en == 4'h0 && !wake_timer_run)
    else $error("clock running in STOP");
  idle_slow_a: assert property (mode == PMCC_IDLE |-> osc_en.slow_crystal != osc_en.slow_internal_rc
                                && !osc_en.fast_crystal && !osc_en.fast_internal_rc && wake_timer_run)
    else $error("IDLE did not keep only the slow clock");
  wake_pin_a: assert property (powered_down_s ##0 pin_low |=> run)
    else $error("low wake pin did not end power-down");
  tick_off_a: assert property (powered_down_s |=> !sysclk_tick)
    else $error("system clock ticked in power-down");
  fast_clock_a: assert property (mode == PMCC_FAST |-> sysclk_fast && general_timer_run && cpu_run)
    else $error("FAST mode clocks not running");
  reuse_vector_a: assert property (mode != PMCC_LOAD && !opt_q[`PMCC_OPT_REUSE]
                                   |=> reset_vector == `PMCC_HALF_ADDR && irq_vector == `PMCC_HALF_ADDR + 11'h001)
    else $error("reuse mode vectors not moved");
  lv_off_a: assert property (mode != PMCC_LOAD && lv_mode == `PMCC_LV_OFF
                             |=> !opt.low_voltage_reset_en && !opt.low_voltage_detect_en)
    else $error("low-voltage reset or detect active when disabled");
  ext_pin_a: assert property (mode != PMCC_LOAD |=> opt.ext_pin_reset_en == $past(opt_q[`PMCC_OPT_XRST]))
    else $error("external reset enable not taken from the option word");

endmodule
`default_nettype wire

// [tb/pmcc_tb.sv]
// Testbench of the power-mode and clock configuration block.
// Assumes the design package and top module are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb import pmcc_pkg::*; ;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [13:0] opt_word;
  logic [10:0] opt_addr, prog_rd_addr, reset_vector, irq_vector;
  logic        sleep_req, ext_irq_wake, wake_timer_irq, prog_rd_blocked;
  logic [5:0]  port_a_wake_n, port_b_wake_n;
  pmcc_mode_t  mode;
  pmcc_osc_t   osc_en;
  pmcc_opt_t   opt;
  logic [4:0]  sysclk_div;
  logic        sysclk_fast, sysclk_tick, cpu_run, general_timer_run;
  logic        pwm_clk_fast_irc, wake_timer_run, wake_timer_src_crystal;
  int          bad_count, check_count;

  // The slave's ready is fed back as the bus ready
  pmcc_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hreadyout, .hresp, .hrdata, .opt_word, .opt_addr, .sleep_req, .ext_irq_wake,
    .wake_timer_irq, .port_a_wake_n, .port_b_wake_n, .prog_rd_addr, .prog_rd_blocked,
    .reset_vector, .irq_vector, .mode, .osc_en, .opt, .sysclk_fast, .sysclk_div, .sysclk_tick,
    .cpu_run, .general_timer_run, .pwm_clk_fast_irc, .wake_timer_run, .wake_timer_src_crystal);

  // Clock of 4 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Sample a little after the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // One single AHB-Lite transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic do_reset(input logic [13:0] w);
    @(posedge hclk);
    opt_word <= w;
    hresetn <= 1'b0;
    cyc(4);
    @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
  endtask

  task automatic prot(input logic [10:0] a, input logic e);
    @(posedge hclk);
    prog_rd_addr <= a;
    cyc(2);
    check(32'(prog_rd_blocked), 32'(e));
  endtask

  // Option word decode, vectors, protection and latching
  task automatic opt_case(input logic [13:0] w, input logic [7:0] eo, input logic [10:0] rv,
      input logic [10:0] a0, input logic b0, input logic [10:0] a1, input logic b1);
    logic [31:0] q;
    do_reset(w);
    check(32'(opt), 32'(eo));
    check(32'(reset_vector), 32'(rv));
    check(32'(irq_vector), 32'(rv + 11'h001));
    check(32'(opt_addr), 32'h7FC);
    @(posedge hclk);
    opt_word <= ~w;
    ahb(1'b1, 32'h18, 32'h0, q);
    ahb(1'b0, 32'h18, 32'h0, q);
    check(q, 32'(w));
    check(32'(opt), 32'(eo));
    prot(a0, b0);
    prot(a1, b1);
  endtask

  task automatic presc;
    logic [31:0] q;
    logic [4:0]  dv [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
    int          n;
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 32'h10, 32'(i), q);
      cyc(2);
      check(32'(sysclk_div), 32'(dv[i]));
      if (i == 1) begin
        n = 0;
        repeat (16) begin
          cyc(1);
          n += 32'(sysclk_tick);
        end
        check(n, 32'h4);
      end
    end
    ahb(1'b1, 32'h10, 32'h123, q);
    ahb(1'b0, 32'h10, 32'h0, q);
    check(q, 32'h103);
    check(32'(pwm_clk_fast_irc), 32'h1);
    ahb(1'b0, 32'h40, 32'h0, q);
    check(q, 32'h0);
    ahb(1'b0, 32'h0C, 32'h0, q);
    check(q, 32'h0);
  endtask

  task automatic clk_wr(input logic [8:0] v);
    logic [31:0] q;
    ahb(1'b1, 32'h10, 32'(v), q);
    cyc(2);
  endtask

  task automatic sleep;
    @(posedge hclk);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    #1;
  endtask

  task automatic wait_mode(input pmcc_mode_t m);
    for (int i = 0; i < 10 && mode !== m; i++) cyc(1);
    check(32'(mode), 32'(m));
  endtask

  // Mode walk: reset state, FAST, SLOW, IDLE, STOP and wakes
  task automatic modes;
    logic [31:0] q;
    do_reset(14'h04C0);
    check(32'(mode), 32'(PMCC_SLOW));
    check(32'(osc_en.slow_internal_rc), 32'h1);
    ahb(1'b0, 32'h10, 32'h0, q);
    check(q, 32'h003);
    ahb(1'b0, 32'h14, 32'h0, q);
    check(q, 32'h2);
    clk_wr(9'h043);
    clk_wr(9'h047);
    check(32'(mode), 32'(PMCC_FAST));
    check(32'(sysclk_fast), 32'h1);
    check(32'(osc_en), 32'h9);
    check(32'(general_timer_run), 32'h1);
    clk_wr(9'h0C7);
    check(32'(osc_en), 32'hA);
    check(32'(wake_timer_src_crystal), 32'h1);
    clk_wr(9'h0CB);
    check(32'(mode), 32'(PMCC_SLOW));
    check(32'(osc_en), 32'h2);
    sleep();
    check(32'(mode), 32'(PMCC_IDLE));
    check(32'(osc_en), 32'h2);
    check(32'({cpu_run, general_timer_run, wake_timer_run}), 32'h1);
    check(32'(opt.watchdog_reset_en), 32'h0);
    @(posedge hclk);
    ext_irq_wake <= 1'b1;
    wait_mode(PMCC_SLOW);
    check(32'(opt.watchdog_reset_en), 32'h1);
    @(posedge hclk);
    ext_irq_wake <= 1'b0;
    clk_wr(9'h0DB);
    ahb(1'b1, 32'h0C, 32'h0, q);
    cyc(1);
    check(32'(mode), 32'(PMCC_STOP));
    check(32'({osc_en, wake_timer_run, cpu_run}), 32'h0);
    @(posedge hclk);
    port_b_wake_n <= 6'h1F;
    wait_mode(PMCC_SLOW);
    @(posedge hclk);
    port_b_wake_n <= 6'h3F;
    clk_wr(9'h0C7);
    sleep();
    check(32'(mode), 32'(PMCC_IDLE));
    @(posedge hclk);
    wake_timer_irq <= 1'b1;
    wait_mode(PMCC_FAST);
    @(posedge hclk);
    wake_timer_irq <= 1'b0;
    clk_wr(9'h0D7);
    sleep();
    check(32'(mode), 32'(PMCC_STOP));
    @(posedge hclk);
    ext_irq_wake <= 1'b1;
    wait_mode(PMCC_FAST);
    @(posedge hclk);
    ext_irq_wake <= 1'b0;
  endtask

  // Watchdog against a hang
  initial begin
    #40000;
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, sleep_req, ext_irq_wake, wake_timer_irq} = '0;
    {haddr, hwdata, htrans, prog_rd_addr} = '0;
    hsize = 3'h2;
    opt_word = 14'h3FFF;
    port_a_wake_n = 6'h3F;
    port_b_wake_n = 6'h3F;
    bad_count = 0;
    check_count = 0;
    opt_case(14'h3FFF, 8'h3B, 11'h000, 11'h000, 1'b0, 11'h7FB, 1'b0);
    opt_case(14'h1000, 8'h8C, 11'h000, 11'h3FF, 1'b1, 11'h400, 1'b0);
    opt_case(14'h04C0, 8'hFD, 11'h400, 11'h7FB, 1'b1, 11'h7FC, 1'b0);
    opt_case(14'h2BFF, 8'h72, 11'h400, 11'h000, 1'b0, 11'h7FB, 1'b0);
    presc();
    modes();
    conclude();
  end
endmodule
`default_nettype wire
